// ===== design/step_option_pkg.sv
// Constants for the trigger step option decoder.
// Assumes one 100 MHz clock and a synchronous active-low reset.
// Operation
// RL1 - Wait options 0-4 select PWM event sources
// RL2 - Wait options 7-15 select OC, IC, CMP, ADC, EXTERNAL_IRQ_2
// RL3 - IRQ step options 0-3 raise interrupts 0-3
// RL4 - Five-bit trigger option selects one of 32 outputs
// RL5 - Reserved commands and options execute as no-ops
// RL6 - Toggle mode inverts output, else pulse of width
// RL7 - Wait step stalls until source reaches level
package step_option_pkg;
   localparam int N_SRC = 16;
   localparam int N_IRQ = 4;
   localparam int N_TRIG = 32;
   localparam int PW_BITS = 4;
   localparam logic [3:0] OPT_RSVD_A = 4'h5;
   localparam logic [3:0] OPT_RSVD_B = 4'h6;
   localparam logic [3:0] OPT_IRQ_LAST = 4'h3;
   localparam logic [31:0] TRIG_RESET = 32'h0;

   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_WAIT_HIGH = 3'h1,
      CMD_WAIT_LOW = 3'h2,
      CMD_IRQ = 3'h3,
      CMD_TRIG = 3'h4
   } cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_WAIT = 2'h1,
      ST_PULSE = 2'h2
   } state_t;
endpackage : step_option_pkg

// ===== design/event_source_mux.sv
// Maps a 4-bit wait option onto the event source bus.
// Assumes the sources are already synchronous to clock.
`timescale 1ns/100ps
module event_source_mux (
   // Event sources, bit index equals option code
   input wire logic [15:0] sources,
   // Selection
   input wire logic [3:0] option,
   output logic level,
   output logic reserved
);
   always_comb begin
      // Codes 5 and 6 have no source; they read low but are flagged as no-op
      reserved = (option == step_option_pkg::OPT_RSVD_A) ||
                 (option == step_option_pkg::OPT_RSVD_B); // see RL5
      level = reserved ? 1'b0 : sources[option]; // see RL1 see RL2
   end
endmodule : event_source_mux

// ===== design/trigger_step_option_decoder.sv
// Step option decoder: wait, interrupt and trigger-output step effects.
// Assumes the sequencer presents one command with cmd_valid and waits for cmd_done.
`timescale 1ns/100ps
module trigger_step_option_decoder #(
   parameter int PW_BITS = step_option_pkg::PW_BITS
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Command from the sequencer
   input wire logic cmd_valid,
   input wire logic [2:0] cmd,
   input wire logic [4:0] option,
   output logic cmd_done,
   // Configuration levels
   input wire logic toggle_mode_select,
   input wire logic [PW_BITS-1:0] pulse_width_field,
   // Event sources: 0 special event, 1 sync, 2-4 pwm, 7 output_compare_1,
   // 8 oc2, 9 input_capture_1, 10-13 comparator_1..4, 14 adc, 15 external_irq_2
   input wire logic [15:0] event_sources,
   // Effects
   output logic [3:0] seq_irq,
   output logic [31:0] trigger_output_n
);
   // Sequencer state group
   step_option_pkg::state_t state;
   step_option_pkg::state_t next_state;
   logic [PW_BITS-1:0] count;
   logic [PW_BITS-1:0] next_count;
   logic [4:0] held_opt;
   logic [4:0] next_held_opt;
   logic held_high;
   logic next_held_high;
   // Trigger output group
   logic [31:0] trig;
   logic [31:0] next_trig;
   // Interrupt group
   logic [3:0] irq;
   logic [3:0] next_irq;
   // Decoded command
   step_option_pkg::cmd_t c;
   logic is_wait;
   logic is_irq;
   logic is_trig;
   logic is_nop;
   logic irq_in_range;
   logic take;
   // Source selection
   logic [3:0] mux_opt;
   logic src_level;
   logic src_reserved;
   logic level_met;
   logic done;

   function automatic logic [31:0] onehot(input logic [4:0] sel);
      onehot = 32'h1 << sel;
   endfunction : onehot

   function automatic logic [3:0] irq_line(input logic [1:0] sel);
      irq_line = 4'h1 << sel;
   endfunction : irq_line

   // Command decode; codes 0 and 5-7 fall through to a no-op
   always_comb begin
      c = step_option_pkg::cmd_t'(cmd);
      is_wait = (c == step_option_pkg::CMD_WAIT_HIGH) || (c == step_option_pkg::CMD_WAIT_LOW);
      is_irq = (c == step_option_pkg::CMD_IRQ);
      is_trig = (c == step_option_pkg::CMD_TRIG);
      is_nop = !(is_wait || is_irq || is_trig); // see RL5
      irq_in_range = (option[3:0] <= step_option_pkg::OPT_IRQ_LAST);
      take = cmd_valid && (state == step_option_pkg::ST_IDLE);
   end

   // While waiting the held option steers the mux, not the live bus
   always_comb begin
      if (state == step_option_pkg::ST_WAIT) begin
         mux_opt = held_opt[3:0];
      end else begin
         mux_opt = option[3:0];
      end
   end

   event_source_mux u_mux (
      .sources(event_sources),
      .option(mux_opt),
      .level(src_level),
      .reserved(src_reserved)
   );

   always_comb begin
      if (state == step_option_pkg::ST_WAIT) begin
         level_met = (src_level == held_high); // see RL7
      end else begin
         level_met = (src_level == (c == step_option_pkg::CMD_WAIT_HIGH)); // see RL7
      end
   end

   // Interrupt group: one-cycle pulse, options 4..15 do nothing
   always_comb begin
      next_irq = 4'h0;
      if (take && is_irq && irq_in_range) begin
         next_irq = irq_line(option[1:0]); // see RL3
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         irq <= 4'h0;
      end else begin
         irq <= next_irq;
      end
   end

   // Trigger output group
   always_comb begin
      next_trig = trig;
      unique case (state)
         step_option_pkg::ST_IDLE: begin
            // Pulse outputs drop back once no pulse is running
            if (!toggle_mode_select) begin
               next_trig = step_option_pkg::TRIG_RESET;
            end
            if (take && is_trig) begin
               if (toggle_mode_select) begin
                  next_trig = trig ^ onehot(option); // see RL4 see RL6
               end else begin
                  next_trig = onehot(option); // see RL4 see RL6
               end
            end
         end
         step_option_pkg::ST_WAIT: begin
            next_trig = trig;
         end
         step_option_pkg::ST_PULSE: begin
            next_trig = onehot(held_opt); // see RL6
         end
         default: next_trig = trig;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         trig <= step_option_pkg::TRIG_RESET;
      end else begin
         trig <= next_trig;
      end
   end

   // Sequencer state group
   always_comb begin
      next_state = state;
      next_count = count;
      next_held_opt = held_opt;
      next_held_high = held_high;
      done = 1'b0;
      unique case (state)
         step_option_pkg::ST_IDLE: begin
            if (take) begin
               if (is_wait) begin
                  if (src_reserved) begin
                     // Reserved source: completes at once, nothing waited on
                     done = 1'b1; // see RL5
                  end else if (level_met) begin
                     done = 1'b1; // see RL7
                  end else begin
                     next_state = step_option_pkg::ST_WAIT;
                     next_held_opt = option;
                     next_held_high = (c == step_option_pkg::CMD_WAIT_HIGH);
                  end
               end else if (is_trig && !toggle_mode_select && pulse_width_field != '0) begin
                  next_held_opt = option;
                  next_count = pulse_width_field;
                  next_state = step_option_pkg::ST_PULSE;
               end else begin
                  // Interrupt, toggle, zero-width pulse and no-op steps end at once
                  done = 1'b1; // see RL5
               end
            end
         end
         step_option_pkg::ST_WAIT: begin
            if (level_met) begin
               done = 1'b1; // see RL7
               next_state = step_option_pkg::ST_IDLE;
            end
         end
         step_option_pkg::ST_PULSE: begin
            // PULSE state lasts pulse_width_field + 1 cycles; the output stays high one cycle longer
            if (count == '0) begin
               done = 1'b1;
               next_state = step_option_pkg::ST_IDLE;
            end else begin
               next_count = count - PW_BITS'(1);
            end
         end
         default: next_state = step_option_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state <= step_option_pkg::ST_IDLE;
         count <= '0;
         held_opt <= 5'h0;
         held_high <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         held_opt <= next_held_opt;
         held_high <= next_held_high;
      end
   end

   assign cmd_done = done;
   assign seq_irq = irq;
   assign trigger_output_n = trig;
endmodule : trigger_step_option_decoder

// ===== testbench/event_model.sv
// Event model: levels show four edges late.
// Assumes want moves on rising edges.
`timescale 1ns/100ps
module event_model (input wire logic clock, input wire logic [15:0] want,
   output logic [15:0] event_sources = 16'h0000);
   logic [47:0] pipe = 48'h0;
   always @(posedge clock) {event_sources, pipe} <= {pipe, want};
endmodule : event_model

// ===== testbench/step_option_sva.sv
// Port checks for the step decoder.
// Assumes cmd_valid is held until cmd_done.
`timescale 1ns/100ps
module step_option_chk (
   // Watched ports
   input wire logic clock, rst_b, cmd_valid, cmd_done, toggle_mode_select,
   input wire logic [2:0] cmd,
   input wire logic [4:0] option,
   input wire logic [15:0] event_sources,
   input wire logic [3:0] seq_irq,
   input wire logic [31:0] trigger_output_n);
   logic idle;
   wire take = cmd_valid && idle;
   wire [3:0] op = option[3:0];
   wire wt = cmd_valid && (cmd == 3'h1 || cmd == 3'h2);
   wire lvl = event_sources[op] ^ cmd[1];
   wire rsv = cmd == 3'h0 || cmd > 3'h4 || wt && (op == 4'h5 || op == 4'h6);
   wire trg = take && cmd == 3'h4;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge clock) idle <= !rst_b || !cmd_valid || cmd_done;
   irq_step_a: assert property (take && cmd == 3'h3 |-> cmd_done ##1
      seq_irq == ($past(op) < 4'h4 ? 4'h1 << $past(op[1:0]) : 4'h0)) else $error("irq");
   wait_pwm_a: assert property (wt && op < 4'h5
      |-> cmd_done == lvl) else $error("pwm wait");
   wait_src_a: assert property (wt && op > 4'h6
      |-> cmd_done == lvl) else $error("source wait");
   nop_step_a: assert property (take && rsv
      |-> cmd_done ##1 !seq_irq && $stable(trigger_output_n)) else $error("nop");
   trig_pick_a: assert property (trg
      |=> trigger_output_n[$past(option)] != $past(trigger_output_n[option])) else $error("pick");
   trig_toggle_a: assert property (trg && toggle_mode_select
      |=> trigger_output_n == ($past(trigger_output_n) ^ 32'h1 << $past(option))) else $error("tgl");
   trig_pulse_a: assert property (trg && !toggle_mode_select
      |=> trigger_output_n == 32'h1 << $past(option)) else $error("pulse");
   cover property (take && cmd == 3'h3);
   cover property (wt && !cmd_done);
   cover property (trg && !toggle_mode_select);
endmodule : step_option_chk
bind trigger_step_option_decoder step_option_chk chk (.*);

// ===== testbench/test_trigger_step_option_decoder.sv
// Bench for the step decoder.
// Assumes a 10 ns clock.
`timescale 1ns/100ps
module test_trigger_step_option_decoder;
   logic clock = 1'h0, rst_b = 1'h0, cmd_valid = 1'h0, toggle_mode_select = 1'h1, cmd_done;
   logic [2:0] cmd = 3'h0;
   logic [4:0] option = 5'h00;
   logic [3:0] pulse_width_field = 4'h2, seq_irq;
   logic [15:0] want = 16'h0000, event_sources;
   logic [31:0] trigger_output_n;
   int fails = 0, cmp_count = 0, n;
   always #5 clock = ~clock;
   event_model model (.*);
   trigger_step_option_decoder dut (.*);
   task check(input logic [31:0] seen, exp, input string what);
      cmp_count++;
      fails += seen !== exp;
      if (seen !== exp) $display("MISMATCH %s exp %h seen %h", what, exp, seen);
   endtask : check
   task send(input logic [2:0] c, input logic [4:0] o);
      @(posedge clock) {cmd_valid, cmd, option} <= {1'h1, c, o};
      #1 n = 0;
      while (cmd_done !== 1'h1 && n < 40) @(posedge clock) #1 n++;
      @(posedge clock) cmd_valid <= 1'h0;
      #1;
   endtask : send
   task t_irq;
      for (int o = 0; o < 16; o++) begin
         send(3'h3, 5'(o));
         check(seq_irq, o < 4 ? 4'h1 << o : 4'h0, "irq");
      end
   endtask : t_irq
   task t_wait(input logic [2:0] c);
      for (int o = 0; o < 16; o++) begin
         @(posedge clock) want <= {16{c[1]}};
         repeat (4) @(posedge clock);
         want <= {16{c[1]}} ^ 16'h1 << o;
         send(c, 5'(o));
         check(n, o == 5 || o == 6 ? 0 : 3, "wait");
      end
   endtask : t_wait
   task t_trig;
      send(3'h4, 5'h1F);
      check(trigger_output_n, 32'h80000000, "toggle");
      @(posedge clock) toggle_mode_select <= 1'h0;
      send(3'h4, 5'h00);
      check(n, 3, "pulse");
      check(trigger_output_n, 32'h00000001, "pulse high");
      @(posedge clock) #1;
      check(trigger_output_n, 32'h00000000, "pulse low");
   endtask : t_trig
   task t_nop;
      send(3'h0, 5'h1F);
      check(n, 0, "nop done");
      check(seq_irq, 4'h0, "nop irq");
      send(3'h7, 5'h03);
      check(n, 0, "rsv done");
      check(seq_irq, 4'h0, "rsv irq");
      check(trigger_output_n, 32'h0, "rsv trig");
   endtask : t_nop
   task give_verdict;
      $display("%0d checks %0d fails", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20) @(posedge clock);
      rst_b <= 1'h1;
      t_irq;
      t_wait(3'h1);
      t_wait(3'h2);
      t_nop;
      t_trig;
      give_verdict;
   end
   // Tests need well under 1000 cycles
   initial begin
      #40000 fails++;
      give_verdict;
   end
endmodule : test_trigger_step_option_decoder
